/* File: common/ptm_map.svh */
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PTM_A_CTRL0   8'h00
`define PTM_A_CTRL1   8'h04
`define PTM_A_CNT_LO  8'h08
`define PTM_A_CNT_HI  8'h0c
`define PTM_A_CMPA_LO 8'h10
`define PTM_A_CMPA_HI 8'h14
`define PTM_A_PER_LO  8'h18
`define PTM_A_PER_HI  8'h1c
`define PTM_A_STATUS  8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define PTM_B_RUN     3
`define PTM_B_EDGE    4
`define PTM_B_MODE    7:6
`define PTM_B_IO      5:4
`define PTM_B_OC      3
`define PTM_B_INV     2
`define PTM_B_CCLR    0
`define PTM_B_FLAG_A  0
`define PTM_B_FLAG_P  1
`define PTM_B_LO      7:0
`define PTM_B_HI      9:8
// ----------------------------------------
// values
// ----------------------------------------
`define PTM_CNT_MAX   10'h3ff
`define PTM_ZERO10    10'h000
`define PTM_ONE10     10'h001
`define PTM_IO_KEEP   2'h0
`define PTM_IO_SINGLE 2'h3
`define PTM_IO_PWM    2'h2
`define PTM_IO_LOW    2'h1
`define PTM_IO_HIGH   2'h2
`define PTM_IO_TOGGLE 2'h3
`define PTM_MODE_CMP  2'h0
`define PTM_MODE_PWM  2'h2
`define PTM_MODE_TMR  2'h3
`endif

/* File: common/ptm_pkg.sv */
package ptm_pkg;
   typedef logic [9:0] ptm_cnt_t;
   typedef struct packed {
      logic        wr_pend;
      logic [7:0]  wadr;
      logic [31:0] rdata;
      logic        ready;
      logic        resp;
      logic [1:0]  mode;
      logic [1:0]  io;
      logic        oc;
      logic        inv;
      logic        cclr;
      logic        edge_fall;
      logic        run;
      logic        run_d;
      ptm_cnt_t    cnt;
      ptm_cnt_t    cmpa;
      ptm_cnt_t    per;
      logic        flag_a;
      logic        flag_p;
      logic        lvl;
      logic        pout;
      logic        poe_n;
      logic [2:0]  ext_sync;
   } ptm_state_s;
endpackage : ptm_pkg

/* File: hw/ptm_timer.sv */
`timescale 1ns/1ns
`include "ptm_map.svh"
module ptm_timer
   import ptm_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        ext_clk_pin,
   output logic             timer_pin_out,
   output logic             timer_pin_oe_n,
   output logic             match_a_flag,
   output logic             match_p_flag
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   ptm_state_s s_r;
   ptm_state_s s_nxt;

   logic     cmp_like;
   logic     pwm_mode;
   logic     sp_mode;
   ptm_cnt_t cnt_inc;
   logic     ticking;
   logic     a_hit;
   logic     p_hit;
   logic     wrap;
   logic     ext_edge;
   logic     pwm_act;
   logic     run_rise;
   logic     set_a;
   logic     set_p;

   always_comb begin
      cmp_like = (s_r.mode == `PTM_MODE_CMP) || (s_r.mode == `PTM_MODE_TMR);
      pwm_mode = (s_r.mode == `PTM_MODE_PWM) && (s_r.io != `PTM_IO_SINGLE);
      sp_mode  = (s_r.mode == `PTM_MODE_PWM) && (s_r.io == `PTM_IO_SINGLE);
      cnt_inc  = ptm_cnt_t'(s_r.cnt + `PTM_ONE10);
      run_rise = s_r.run && !s_r.run_d;
      ticking  = s_r.run && !run_rise;
      wrap     = ticking && (s_r.cnt == `PTM_CNT_MAX);
      a_hit    = ticking && (s_r.cmpa != `PTM_ZERO10) && (cnt_inc == s_r.cmpa);
      p_hit    = ticking && ((s_r.per == `PTM_ZERO10) ? wrap
                                                      : (cnt_inc == s_r.per));
      ext_edge = s_r.edge_fall ? (s_r.ext_sync[2] && !s_r.ext_sync[1])
                               : (!s_r.ext_sync[2] && s_r.ext_sync[1]);
      pwm_act  = ((s_r.per != `PTM_ZERO10) && (s_r.cmpa >= s_r.per))
                 || (s_r.cnt < s_r.cmpa);
      // hardware flag sets, mode 01 raises none
      set_a    = a_hit && (cmp_like || pwm_mode || sp_mode);
      set_p    = p_hit && ((cmp_like && !s_r.cclr) || pwm_mode);
   end

   always_comb begin
      s_nxt          = s_r;
      s_nxt.ready    = 1'b1;
      s_nxt.resp     = 1'b0;
      s_nxt.ext_sync = {s_r.ext_sync[1:0], ext_clk_pin};
      s_nxt.run_d    = s_r.run;
      // ----------------------------------------
      // counter and flags
      // ----------------------------------------
      if (run_rise) begin
         s_nxt.cnt = `PTM_ZERO10;
         s_nxt.lvl = s_r.oc;
      end else if (ticking) begin
         s_nxt.cnt = cnt_inc;
         if (cmp_like) begin
            if (!s_r.cclr) begin
               if (p_hit) s_nxt.cnt = `PTM_ZERO10;
               s_nxt.flag_a = s_r.flag_a | a_hit;
               s_nxt.flag_p = s_r.flag_p | p_hit;
            end else begin
               if (a_hit) s_nxt.cnt = `PTM_ZERO10;
               s_nxt.flag_a = s_r.flag_a | a_hit;
            end
            if (a_hit && s_r.mode == `PTM_MODE_CMP) begin
               unique case (s_r.io)
                  `PTM_IO_KEEP:   s_nxt.lvl = s_r.lvl;
                  `PTM_IO_LOW:    s_nxt.lvl = 1'b0;
                  `PTM_IO_HIGH:   s_nxt.lvl = 1'b1;
                  `PTM_IO_TOGGLE: s_nxt.lvl = !s_r.lvl;
               endcase
            end
         end else if (pwm_mode) begin
            if (p_hit) s_nxt.cnt = `PTM_ZERO10;
            s_nxt.flag_a = s_r.flag_a | a_hit;
            s_nxt.flag_p = s_r.flag_p | p_hit;
         end else if (sp_mode) begin
            if (a_hit) begin
               s_nxt.run    = 1'b0;
               s_nxt.flag_a = s_r.flag_a | 1'b1;
            end
         end
      end
      if (sp_mode && ext_edge && !s_r.run) s_nxt.run = 1'b1;
      // ----------------------------------------
      // bus data phase: write
      // ----------------------------------------
      s_nxt.wr_pend = 1'b0;
      if (s_r.wr_pend) begin
         unique case (s_r.wadr)
            `PTM_A_CTRL0: begin
               s_nxt.run       = hwdata[`PTM_B_RUN];
               s_nxt.edge_fall = hwdata[`PTM_B_EDGE];
            end
            `PTM_A_CTRL1: begin
               s_nxt.mode = hwdata[`PTM_B_MODE];
               s_nxt.io   = hwdata[`PTM_B_IO];
               s_nxt.oc   = hwdata[`PTM_B_OC];
               s_nxt.inv  = hwdata[`PTM_B_INV];
               s_nxt.cclr = hwdata[`PTM_B_CCLR];
            end
            `PTM_A_CMPA_LO: s_nxt.cmpa[`PTM_B_LO] = hwdata[7:0];
            `PTM_A_CMPA_HI: s_nxt.cmpa[`PTM_B_HI] = hwdata[1:0];
            `PTM_A_PER_LO:  s_nxt.per[`PTM_B_LO]  = hwdata[7:0];
            `PTM_A_PER_HI:  s_nxt.per[`PTM_B_HI]  = hwdata[1:0];
            `PTM_A_STATUS: begin
               // hardware set in this cycle wins over the clear
               s_nxt.flag_a = (s_r.flag_a & !hwdata[`PTM_B_FLAG_A]) | set_a;
               s_nxt.flag_p = (s_r.flag_p & !hwdata[`PTM_B_FLAG_P]) | set_p;
            end
            default: ;
         endcase
      end
      // ----------------------------------------
      // bus address phase
      // ----------------------------------------
      if (hsel && htrans[1] && hready) begin
         s_nxt.wr_pend = hwrite;
         s_nxt.wadr    = haddr[7:0];
         s_nxt.rdata   = 32'h0000_0000;
         if (!hwrite) begin
            unique case (haddr[7:0])
               `PTM_A_CTRL0: begin
                  s_nxt.rdata[`PTM_B_RUN]  = s_r.run;
                  s_nxt.rdata[`PTM_B_EDGE] = s_r.edge_fall;
               end
               `PTM_A_CTRL1:   s_nxt.rdata[7:0] = {s_r.mode, s_r.io, s_r.oc, s_r.inv,
                                                   1'b0, s_r.cclr};
               `PTM_A_CNT_LO:  s_nxt.rdata[7:0] = s_r.cnt[`PTM_B_LO];
               `PTM_A_CNT_HI:  s_nxt.rdata[1:0] = s_r.cnt[`PTM_B_HI];
               `PTM_A_CMPA_LO: s_nxt.rdata[7:0] = s_r.cmpa[`PTM_B_LO];
               `PTM_A_CMPA_HI: s_nxt.rdata[1:0] = s_r.cmpa[`PTM_B_HI];
               `PTM_A_PER_LO:  s_nxt.rdata[7:0] = s_r.per[`PTM_B_LO];
               `PTM_A_PER_HI:  s_nxt.rdata[1:0] = s_r.per[`PTM_B_HI];
               `PTM_A_STATUS:  s_nxt.rdata[1:0] = {s_r.flag_p, s_r.flag_a};
               default: ;
            endcase
         end
      end
      // ----------------------------------------
      // pin
      // ----------------------------------------
      if (pwm_mode) begin
         unique case (s_r.io)
            `PTM_IO_KEEP: s_nxt.lvl = !s_r.oc;
            `PTM_IO_LOW: s_nxt.lvl = s_r.oc;
            default:     s_nxt.lvl = pwm_act ? s_r.oc : !s_r.oc;
         endcase
      end else if (sp_mode) begin
         s_nxt.lvl = s_nxt.run ? s_r.oc : !s_r.oc;
      end
      s_nxt.pout  = s_nxt.lvl ^ s_nxt.inv;
      s_nxt.poe_n = (s_nxt.mode == `PTM_MODE_TMR);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata         = s_r.rdata;
   assign hreadyout      = s_r.ready;
   assign hresp          = s_r.resp;
   assign timer_pin_out  = s_r.pout;
   assign timer_pin_oe_n = s_r.poe_n;
   assign match_a_flag   = s_r.flag_a;
   assign match_p_flag   = s_r.flag_p;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_run_rise;
      s_r.run && !s_r.run_d;
   endsequence

   property p_cclr_p;
      cmp_like && !s_r.cclr && p_hit && !s_r.wr_pend |=> s_r.cnt == `PTM_ZERO10 && s_r.flag_p;
   endproperty
   a_cclr_p: assert property (p_cclr_p) else $error("period match did not clear");

   property p_cclr_a;
      cmp_like && s_r.cclr && p_hit && !a_hit && !s_r.flag_p && !s_r.wr_pend |=> !s_r.flag_p;
   endproperty
   a_cclr_a: assert property (p_cclr_a) else $error("period flag in clear A mode");

   property p_zero_a;
      ticking && s_r.cmpa == `PTM_ZERO10 && !s_r.flag_a && !s_r.wr_pend |=> !s_r.flag_a;
   endproperty
   a_zero_a: assert property (p_zero_a) else $error("A flag with zero compare");

   property p_init_lvl;
      s_run_rise ##0 (s_r.mode == `PTM_MODE_CMP) ##0 !s_r.wr_pend
         |=> timer_pin_out == ($past(s_r.oc) ^ $past(s_r.inv));
   endproperty
   a_init_lvl: assert property (p_init_lvl) else $error("initial level not loaded");

   property p_tmr_oe;
      s_r.mode == `PTM_MODE_TMR && !s_r.wr_pend |=> timer_pin_oe_n;
   endproperty
   a_tmr_oe: assert property (p_tmr_oe) else $error("pin driven in timer mode");

   property p_no_change;
      s_r.mode == `PTM_MODE_CMP && s_r.io == 2'h0 && !run_rise && !s_r.wr_pend
         |=> $stable(s_r.lvl);
   endproperty
   a_no_change: assert property (p_no_change) else $error("pin moved with action zero");

   property p_sp_stop;
      sp_mode && a_hit && !s_r.wr_pend |=> !s_r.run ##1 $stable(s_r.cnt);
   endproperty
   a_sp_stop: assert property (p_sp_stop) else $error("single pulse not stopped");

   property p_sp_trig;
      sp_mode && ext_edge && !s_r.run && !s_r.wr_pend |=> s_r.run ##1 s_r.cnt == `PTM_ZERO10;
   endproperty
   a_sp_trig: assert property (p_sp_trig) else $error("external edge did not start");

   property p_pwm_full;
      pwm_mode && s_r.io == `PTM_IO_PWM && s_r.per != `PTM_ZERO10 && s_r.cmpa >= s_r.per
         && !s_r.wr_pend |=> s_r.lvl == s_r.oc;
   endproperty
   a_pwm_full: assert property (p_pwm_full) else $error("full duty not active");

   property p_pwm_wrap;
      pwm_mode && p_hit && !s_r.wr_pend |=> s_r.cnt == `PTM_ZERO10 && s_r.flag_p;
   endproperty
   a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm period not cleared");

   property p_rdy;
      hready |-> ##1 hreadyout && !hresp;
   endproperty
   a_rdy: assert property (p_rdy) else $error("bus not ready");

   // ----------------------------------------
   // flag, register and pin checks
   // ----------------------------------------
   sequence s_status_wr;
      s_r.wr_pend && s_r.wadr == `PTM_A_STATUS;
   endsequence

   property p_flag_set;
      set_a |=> s_r.flag_a;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("match A flag not set");

   property p_flag_p_set;
      set_p |=> s_r.flag_p;
   endproperty
   a_flag_p_set: assert property (p_flag_p_set) else $error("match P flag not set");

   property p_flag_clr;
      s_status_wr ##0 (hwdata[`PTM_B_FLAG_A] && !set_a) |=> !s_r.flag_a;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("match A flag not cleared");

   property p_per_wr;
      s_r.wr_pend && s_r.wadr == `PTM_A_PER_LO |=> s_r.per[`PTM_B_LO] == $past(hwdata[7:0]);
   endproperty
   a_per_wr: assert property (p_per_wr) else $error("period low byte not written");

   property p_rd_hi;
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] == `PTM_A_PER_HI
         |=> hrdata[31:2] == 30'h0;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("period upper bits not zero");

   property p_oe_cmp;
      s_r.mode == `PTM_MODE_CMP && !s_r.wr_pend |=> !timer_pin_oe_n;
   endproperty
   a_oe_cmp: assert property (p_oe_cmp) else $error("pin not driven in compare mode");

   property p_cmp_low;
      s_r.mode == `PTM_MODE_CMP && a_hit && s_r.io == `PTM_IO_LOW && !s_r.wr_pend |=> !s_r.lvl;
   endproperty
   a_cmp_low: assert property (p_cmp_low) else $error("pin not driven low");

   property p_cmp_high;
      s_r.mode == `PTM_MODE_CMP && a_hit && s_r.io == `PTM_IO_HIGH && !s_r.wr_pend |=> s_r.lvl;
   endproperty
   a_cmp_high: assert property (p_cmp_high) else $error("pin not driven high");

   property p_cmp_toggle;
      s_r.mode == `PTM_MODE_CMP && a_hit && s_r.io == `PTM_IO_TOGGLE && !s_r.wr_pend
         |=> s_r.lvl != $past(s_r.lvl);
   endproperty
   a_cmp_toggle: assert property (p_cmp_toggle) else $error("pin not toggled");

   property p_cmp_p_only;
      s_r.mode == `PTM_MODE_CMP && p_hit && !a_hit && !s_r.wr_pend |=> $stable(s_r.lvl);
   endproperty
   a_cmp_p_only: assert property (p_cmp_p_only) else $error("period match moved pin");

   property p_tmr_lvl;
      s_r.mode == `PTM_MODE_TMR && !run_rise && !s_r.wr_pend |=> $stable(s_r.lvl);
   endproperty
   a_tmr_lvl: assert property (p_tmr_lvl) else $error("level moved in timer mode");

   property p_pwm_inact;
      pwm_mode && s_r.io == `PTM_IO_KEEP && !s_r.wr_pend |=> s_r.lvl != $past(s_r.oc);
   endproperty
   a_pwm_inact: assert property (p_pwm_inact) else $error("forced inactive lost");

   property p_pwm_act;
      pwm_mode && s_r.io == `PTM_IO_LOW && !s_r.wr_pend |=> s_r.lvl == $past(s_r.oc);
   endproperty
   a_pwm_act: assert property (p_pwm_act) else $error("forced active lost");

   property p_pwm_cclr;
      pwm_mode && s_r.cclr && p_hit && !s_r.wr_pend |=> s_r.cnt == `PTM_ZERO10;
   endproperty
   a_pwm_cclr: assert property (p_pwm_cclr) else $error("clear select changed pwm");

   property p_sp_count;
      sp_mode && ticking && !a_hit && !s_r.wr_pend |=> s_r.cnt == $past(cnt_inc);
   endproperty
   a_sp_count: assert property (p_sp_count) else $error("pulse counter cleared");

   property p_sp_no_p;
      sp_mode && !s_r.flag_p && !s_r.wr_pend |=> !s_r.flag_p;
   endproperty
   a_sp_no_p: assert property (p_sp_no_p) else $error("period flag in pulse mode");

   property p_sp_idle;
      sp_mode && !s_r.run && !ext_edge && !s_r.wr_pend |=> s_r.lvl != $past(s_r.oc);
   endproperty
   a_sp_idle: assert property (p_sp_idle) else $error("pulse active while stopped");

   property p_sync;
      s_r.ext_sync[0] == $past(ext_clk_pin);
   endproperty
   a_sync: assert property (p_sync) else $error("trigger pin not sampled");
endmodule : ptm_timer

/* File: verification/ptm_timer_tb_top.sv */
`timescale 1ns/1ns
`include "ptm_map.svh"
module ptm_timer_tb_top
   import ptm_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hready, ext_clk_pin;
   logic [31:0] haddr, hwdata, hrdata, rd, sv;
   logic [1:0]  htrans, iv;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, timer_pin_out, timer_pin_oe_n, match_a_flag, match_p_flag;
   logic        oc;
   int          n_mismatch, check_count, k, w;
   // ----------------------------------------
   // pwm table: control, compare a, period, window, high count, status (-1 skip)
   // ----------------------------------------
   localparam logic [7:0] pc1 [9] = '{8'ha8, 8'ha9, 8'ha8, 8'ha8, 8'h88, 8'h98, 8'ha0, 8'hac,
                                      8'ha8};
   localparam logic [9:0] pa  [9] = '{10'h3, 10'h3, 10'h9, 10'h8, 10'h3, 10'h3, 10'h3, 10'h3,
                                      10'h100};
   localparam logic [9:0] pp  [9] = '{10'h8, 10'h8, 10'h8, 10'h8, 10'h8, 10'h8, 10'h8, 10'h8,
                                      10'h0};
   localparam int         pn  [9] = '{32, 32, 32, 32, 32, 32, 32, 32, 1024};
   localparam int         ph  [9] = '{12, 12, 32, 32, 0, 32, 20, 20, 256};
   localparam int         ps  [9] = '{3, 3, -1, 3, 3, 3, 3, 3, -1};

   assign hready = hreadyout;

   ptm_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_clk_pin(ext_clk_pin),
      .timer_pin_out(timer_pin_out), .timer_pin_oe_n(timer_pin_oe_n),
      .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // ----------------------------------------
   // report and bus tasks
   // ----------------------------------------
   task stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_hr;
      int i;
      i = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         i++;
         if (i > 50) begin
            n_mismatch++;
            stop_test;
         end
         @(posedge hclk);
      end
   endtask : wait_hr

   // address phase held until hready, then data phase until hready
   task automatic xfer(input logic [7:0] a, input logic wn, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wn;
      wait_hr;
      htrans <= 2'h0;
      hwdata <= d;
      wait_hr;
      rd = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(rd, e);
   endtask : rchk

   task automatic setup(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p,
                        input logic run);
      wr(`PTM_A_CTRL0, 32'h0);
      wr(`PTM_A_STATUS, 32'h3);
      wr(`PTM_A_CMPA_LO, {24'h0, a[7:0]});
      wr(`PTM_A_CMPA_HI, {30'h0, a[9:8]});
      wr(`PTM_A_PER_LO, {24'h0, p[7:0]});
      wr(`PTM_A_PER_HI, {30'h0, p[9:8]});
      wr(`PTM_A_CTRL1, {24'h0, c1});
      wr(`PTM_A_CTRL0, {28'h0, run, 3'h0});
   endtask : setup

   // bounded waits on pin level or the match a flag
   task automatic wsig(input logic flag, input logic v);
      int i;
      for (i = 0; i < 2000 && (flag ? match_a_flag : timer_pin_out) !== v; i++) begin
         @(posedge hclk);
         #1;
      end
      if (i == 2000) begin
         n_mismatch++;
         stop_test;
      end
   endtask : wsig

   task automatic cnt_hi(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge hclk);
         #1;
         if (timer_pin_out === 1'b1) c++;
      end
   endtask : cnt_hi
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; ext_clk_pin = 1'b0; n_mismatch = 0; check_count = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(`PTM_A_PER_LO, 32'h0);
      rchk(`PTM_A_PER_HI, 32'h0);
      wr(`PTM_A_PER_LO, 32'hffff_ffa5);
      wr(`PTM_A_PER_HI, 32'hffff_ffff);
      rchk(`PTM_A_PER_LO, 32'ha5);
      rchk(`PTM_A_PER_HI, 32'h3);
      rchk(8'h40, 32'h0);
      chk(hresp, 1'b0);
      // compare mode, every pin action
      for (int io = 0; io < 4; io++) begin
         iv = io[1:0];
         oc = ~iv[1];
         setup({2'h0, iv, oc, 3'h0}, 10'd5, 10'd8, 1'b1);
         @(posedge hclk);
         #1;
         chk(timer_pin_out, oc);
         chk(timer_pin_oe_n, 1'b0);
         wsig(1'b1, 1'b1);
         repeat (2) @(posedge hclk);
         #1;
         chk(timer_pin_out, iv != 2'h1);
         rchk(`PTM_A_STATUS, 32'h3);
      end
      setup(8'hc0, 10'd5, 10'd8, 1'b1);
      repeat (20) @(posedge hclk);
      #1;
      chk(timer_pin_oe_n, 1'b1);
      chk(match_p_flag, 1'b1);
      rchk(`PTM_A_STATUS, 32'h3);
      setup(8'h01, 10'd5, 10'd3, 1'b1);
      repeat (40) @(posedge hclk);
      rchk(`PTM_A_STATUS, 32'h1);
      setup(8'h01, 10'd0, 10'd0, 1'b1);
      repeat (1100) @(posedge hclk);
      rchk(`PTM_A_STATUS, 32'h0);
      // pwm table
      for (int t = 0; t < 9; t++) begin
         setup(pc1[t], pa[t], pp[t], 1'b1);
         repeat (10) @(posedge hclk);
         cnt_hi(pn[t], k);
         chk(k, ph[t]);
         if (ps[t] >= 0) rchk(`PTM_A_STATUS, ps[t]);
      end
      // single pulse from the trigger pin, pin action kept at 11
      setup(8'hb8, 10'd6, 10'd0, 1'b0);
      ext_clk_pin <= 1'b1;
      wsig(1'b0, 1'b1);
      w = 0;
      while (timer_pin_out === 1'b1 && w < 50) begin
         @(posedge hclk);
         #1;
         w++;
      end
      chk(w >= 5 && w <= 7, 1'b1);
      rchk(`PTM_A_CTRL0, 32'h0);
      rchk(`PTM_A_STATUS, 32'h1);
      xfer(`PTM_A_CNT_LO, 1'b0, 32'h0);
      sv = rd;
      repeat (8) @(posedge hclk);
      rchk(`PTM_A_CNT_LO, sv);
      chk(sv != 32'h0, 1'b1);
      // falling trigger edge, software stop ends a long pulse
      wr(`PTM_A_CTRL0, 32'h10);
      wr(`PTM_A_CMPA_LO, 32'h64);
      ext_clk_pin <= 1'b0;
      wsig(1'b0, 1'b1);
      rchk(`PTM_A_CTRL0, 32'h18);
      repeat (10) @(posedge hclk);
      wr(`PTM_A_CTRL0, 32'h0);
      repeat (2) @(posedge hclk);
      #1;
      chk(timer_pin_out, 1'b0);
      stop_test;
   end
endmodule : ptm_timer_tb_top
